/* File: logic/sdpr_map.svh */
// Purpose: Constants for the SDRAM precharge and refresh control block
// Assumes: 50 MHz core clock
// Notes: Timing counts derive from times in ns
`ifndef SDPR_MAP_SVH
`define SDPR_MAP_SVH
`define SDPR_CLK_PERIOD_NS 20
`define SDPR_T_RP_NS 20
`define SDPR_T_RAS_NS 50
`define SDPR_T_RFC_NS 70
`define SDPR_T_XSR_NS 80
`define SDPR_RP_CYC (((`SDPR_T_RP_NS + `SDPR_CLK_PERIOD_NS - 1) / `SDPR_CLK_PERIOD_NS) < 1 ? 1 : \
   ((`SDPR_T_RP_NS + `SDPR_CLK_PERIOD_NS - 1) / `SDPR_CLK_PERIOD_NS))
`define SDPR_RFC_CYC ((`SDPR_T_RFC_NS + `SDPR_CLK_PERIOD_NS - 1) / `SDPR_CLK_PERIOD_NS)
`define SDPR_XSR_CYC ((`SDPR_T_XSR_NS + `SDPR_CLK_PERIOD_NS - 1) / `SDPR_CLK_PERIOD_NS)
`define SDPR_PRE_SEL_BIT 10
`define SDPR_ROWS 8192
`define SDPR_BL_FULL 3'h7
`define SDPR_SELF_DIV 16'h0100
`endif

/* File: logic/sdpr_pkg.sv */
// Purpose: Types for the SDRAM precharge and refresh control block
// Assumes: Commands decoded from cs/ras/cas/we
// Notes: Burst length code 7 means full page
package sdpr_pkg;
   typedef enum logic [3:0] {
      SDPR_CMD_NOP = 4'h0,
      SDPR_CMD_ACT = 4'h1,
      SDPR_CMD_RD = 4'h2,
      SDPR_CMD_WR = 4'h3,
      SDPR_CMD_BST = 4'h4,
      SDPR_CMD_PRE = 4'h5,
      SDPR_CMD_REF = 4'h6,
      SDPR_CMD_LMR = 4'h7
   } sdpr_cmd_e;
   typedef struct packed {
      logic cs_n;
      logic ras_n;
      logic cas_n;
      logic we_n;
      logic cke;
      logic [1:0] bank;
      logic [12:0] addr;
   } sdpr_cmd_s;
   typedef struct packed {
      logic pre_valid;
      logic [1:0] pre_bank;
      logic ref_valid;
      logic [12:0] ref_row;
   } sdpr_act_s;
endpackage

/* File: logic/sdpr_self_osc.sv */
// Purpose: Internal refresh tick generator for self refresh
// Assumes: Core clock stands in for the internal oscillator
// Notes: Tick is a one-cycle enable pulse
`timescale 1ns/1ns
`include "sdpr_map.svh"
module sdpr_self_osc #(
   parameter logic [15:0] DIV = `SDPR_SELF_DIV
) (
   // Clock and reset
   input wire logic i_core_clk,
   input wire logic i_srst,
   // Control
   input wire logic i_run,
   output logic o_tick
);
   logic [15:0] cnt_ff;
   always_ff @(posedge i_core_clk) begin
      if (i_srst || !i_run) begin
         cnt_ff <= 16'h0000;
      end else if (cnt_ff == DIV - 16'h0001) begin
         cnt_ff <= 16'h0000;
      end else begin
         cnt_ff <= cnt_ff + 16'h0001;
      end
   end
   assign o_tick = i_run && (cnt_ff == DIV - 16'h0001);
endmodule // sdpr_self_osc

/* File: logic/sdpr_ctrl.sv */
// Purpose: Device-side auto precharge, burst terminate and refresh control
// Assumes: Pins synchronised here; controller keeps its own timing rules
// Notes: Outputs tell the array which bank to precharge and row to refresh
// Operation
// R1: Read or write with precharge bit high precharges that bank after burst.
// R2: Full-page bursts never auto precharge.
// R3: Auto precharge flag belongs only to its own access command.
// R4: Precharge starts at the earliest valid point of the burst.
// R5: Controller waits precharge period before using that bank again.
// R6: Burst terminate truncates fixed-length and full-page bursts.
// R7: Terminate hits the most recently registered read or write burst.
// R8: Controller issues one auto refresh command per refresh needed.
// R9: Auto refresh row comes from internal counter, address ignored.
// R10: Controller issues 8192 refreshes per refresh period.
// R11: Controller may burst all 8192 refreshes at row cycle rate.
// R12: Self refresh entry is refresh encoding with clock enable low.
// R13: In self refresh only clock enable is observed.
// R14: Self refresh refreshes autonomously from internal clocking.
// R15: Controller stays in self refresh at least row active time.
// R16: Controller ensures stable clock before raising clock enable.
// R17: Controller sends only NOPs for exit time, at least two clocks.
// R18: Controller resumes auto refresh after self refresh exit.
// R19: Refresh encoding is auto refresh with clock enable high, else self.
// R20: Precharge bit high enables auto precharge, low disables it.
// R21: Controller waits exit time before an active command.
// R22: Controller schedules refreshes and holds accesses while one is pending.
`timescale 1ns/1ns
`include "sdpr_map.svh"
module sdpr_ctrl
   import sdpr_pkg::*;
#(
   parameter int ROW_W = 13
) (
   // Clock and reset
   input wire logic i_core_clk,
   input wire logic i_srst,
   // Command pins
   input wire sdpr_pkg::sdpr_cmd_s i_cmd,
   // Mode: burst length code, 7 is full page
   input wire logic [2:0] i_burst_len,
   // Array actions
   output sdpr_pkg::sdpr_act_s o_act,
   output logic o_self_refresh,
   output logic o_burst_active
);
   import sdpr_pkg::*;

   typedef enum logic [1:0] {
      SDPR_ST_NORMAL = 2'b00,
      SDPR_ST_SELF = 2'b01,
      SDPR_ST_EXIT = 2'b10
   } sdpr_st_e;

   function automatic sdpr_cmd_e decode(input sdpr_cmd_s c);
      if (c.cs_n) begin
         decode = SDPR_CMD_NOP;
      end else begin
         case ({c.ras_n, c.cas_n, c.we_n})
            3'h3: decode = SDPR_CMD_ACT;
            3'h5: decode = SDPR_CMD_RD;
            3'h4: decode = SDPR_CMD_WR;
            3'h6: decode = SDPR_CMD_BST;
            3'h2: decode = SDPR_CMD_PRE;
            3'h1: decode = SDPR_CMD_REF;
            3'h0: decode = SDPR_CMD_LMR;
            default: decode = SDPR_CMD_NOP;
         endcase
      end
   endfunction

   function automatic logic [8:0] burst_beats(input logic [2:0] code);
      case (code)
         3'h0: burst_beats = 9'h001;
         3'h1: burst_beats = 9'h002;
         3'h2: burst_beats = 9'h004;
         3'h3: burst_beats = 9'h008;
         default: burst_beats = 9'h000;
      endcase
   endfunction

   sdpr_cmd_s sync1_ff;
   sdpr_cmd_s sync2_ff;
   sdpr_cmd_e cmd;
   sdpr_st_e st_ff;
   logic [8:0] beats_ff;
   logic burst_ff;
   logic ap_ff;
   logic [1:0] bank_ff;
   logic [ROW_W-1:0] row_cnt_ff;
   logic [7:0] xsr_ff;
   logic self_tick;
   logic last_beat;
   logic is_access;
   sdpr_act_s act_ff;

   // Pins pass two flops
   always_ff @(posedge i_core_clk) begin
      if (i_srst) begin
         sync1_ff <= '{cs_n: 1'b1, ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1, cke: 1'b1, default: '0};
         sync2_ff <= '{cs_n: 1'b1, ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1, cke: 1'b1, default: '0};
      end else begin
         sync1_ff <= i_cmd;
         sync2_ff <= sync1_ff;
      end
   end

   // R13: commands ignored outside normal state
   assign cmd = (st_ff == SDPR_ST_NORMAL) ? decode(sync2_ff) : SDPR_CMD_NOP;
   assign is_access = (cmd == SDPR_CMD_RD) || (cmd == SDPR_CMD_WR);
   assign last_beat = burst_ff && (beats_ff == 9'h001);

   // R7: new access replaces tracked burst
   always_ff @(posedge i_core_clk) begin
      if (i_srst) begin
         burst_ff <= 1'b0;
         beats_ff <= 9'h000;
         bank_ff <= 2'h0;
      end else if (is_access) begin
         burst_ff <= 1'b1;
         beats_ff <= burst_beats(i_burst_len);
         bank_ff <= sync2_ff.bank;
      end else if (cmd == SDPR_CMD_BST) begin
         // R6: truncate any burst
         burst_ff <= 1'b0;
         beats_ff <= 9'h000;
      end else if (last_beat) begin
         burst_ff <= 1'b0;
         beats_ff <= 9'h000;
      end else if (burst_ff && beats_ff != 9'h000) begin
         beats_ff <= beats_ff - 9'h001;
      end
   end

   // R3: flag latched per access only
   always_ff @(posedge i_core_clk) begin
      if (i_srst) begin
         ap_ff <= 1'b0;
      end else if (is_access) begin
         // R20: precharge bit selects
         // R2: never for full page
         ap_ff <= sync2_ff.addr[`SDPR_PRE_SEL_BIT] && (i_burst_len != `SDPR_BL_FULL);
      end else if (last_beat || cmd == SDPR_CMD_BST) begin
         ap_ff <= 1'b0;
      end
   end

   // Self refresh state machine
   always_ff @(posedge i_core_clk) begin
      if (i_srst) begin
         st_ff <= SDPR_ST_NORMAL;
         xsr_ff <= 8'h00;
      end else begin
         case (st_ff)
            SDPR_ST_NORMAL: begin
               // R19: low clock enable means self refresh
               if (decode(sync2_ff) == SDPR_CMD_REF && !sync2_ff.cke) begin
                  st_ff <= SDPR_ST_SELF;
               end
            end
            SDPR_ST_SELF: begin
               // R13: only clock enable watched
               if (sync2_ff.cke) begin
                  st_ff <= SDPR_ST_EXIT;
                  xsr_ff <= 8'(`SDPR_XSR_CYC);
               end
            end
            SDPR_ST_EXIT: begin
               if (xsr_ff <= 8'h01) begin
                  st_ff <= SDPR_ST_NORMAL;
                  xsr_ff <= 8'h00;
               end else begin
                  xsr_ff <= xsr_ff - 8'h01;
               end
            end
            default: st_ff <= SDPR_ST_NORMAL;
         endcase
      end
   end

   // R14: internal refresh timing
   sdpr_self_osc #(
      .DIV(`SDPR_SELF_DIV)
   ) u_osc (
      .i_core_clk(i_core_clk),
      .i_srst(i_srst),
      .i_run(st_ff == SDPR_ST_SELF),
      .o_tick(self_tick)
   );

   // Array actions and refresh counter
   always_ff @(posedge i_core_clk) begin
      if (i_srst) begin
         act_ff <= '0;
         row_cnt_ff <= '0;
      end else begin
         // R1: precharge addressed bank on completion
         // R4: issued the cycle after the final beat
         act_ff.pre_valid <= ap_ff && last_beat && !is_access && cmd != SDPR_CMD_BST;
         act_ff.pre_bank <= bank_ff;
         act_ff.ref_valid <= 1'b0;
         // R9: row from counter, address ignored
         if ((cmd == SDPR_CMD_REF && sync2_ff.cke) || self_tick) begin
            act_ff.ref_valid <= 1'b1;
            act_ff.ref_row <= row_cnt_ff;
            row_cnt_ff <= (row_cnt_ff == ROW_W'(`SDPR_ROWS - 1)) ? '0 : row_cnt_ff + 1'b1;
         end
      end
   end

   assign o_act = act_ff;
   assign o_self_refresh = (st_ff != SDPR_ST_NORMAL);
   assign o_burst_active = burst_ff;
endmodule // sdpr_ctrl

/* File: test/sdpr_ctrl_properties.sv */
// Purpose: Port checks for sdpr_ctrl
// Assumes: Pins acted on two cycles after sampling
// Notes: Bound into every sdpr_ctrl
`timescale 1ns/1ns
module sdpr_chk (
   // Clock and reset
   input wire logic i_core_clk,
   input wire logic i_srst,
   // Watched ports
   input wire sdpr_pkg::sdpr_cmd_s i_cmd,
   input wire logic [2:0] i_burst_len,
   input wire sdpr_pkg::sdpr_act_s o_act,
   input wire logic o_self_refresh,
   input wire logic o_burst_active
);
   import sdpr_pkg::*;
   logic [3:0] pins;
   logic acc, bst, rf, ap_ff;
   logic [12:0] row_ff;
   assign pins = {i_cmd.cs_n, i_cmd.ras_n, i_cmd.cas_n, i_cmd.we_n};
   assign acc = pins[3:1] == 3'h2;
   assign bst = pins == 4'h6;
   assign rf = pins == 4'h1;
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (i_srst);
   // Newest access decides on auto precharge
   always_ff @(posedge i_core_clk) begin
      if (i_srst) begin
         ap_ff <= 1'b0;
         row_ff <= 13'h0;
      end else begin
         if ((acc || bst) && !o_self_refresh)
            ap_ff <= acc && i_cmd.addr[10] && i_burst_len != 3'h7;
         if (o_act.ref_valid)
            row_ff <= row_ff + 13'h1;
      end
   end
   ref_pulse_a: assert property (rf && i_cmd.cke && !o_self_refresh |-> ##3 o_act.ref_valid)
      else $error("auto refresh not acted on");
   ref_row_a: assert property (o_act.ref_valid |-> o_act.ref_row == row_ff)
      else $error("refresh row out of sequence");
   self_entry_a: assert property (rf && !i_cmd.cke && !o_self_refresh |-> ##3 o_self_refresh)
      else $error("self refresh not entered");
   self_exit_a: assert property (o_self_refresh && $rose(i_cmd.cke) |-> o_self_refresh[*7] ##1 !o_self_refresh)
      else $error("self refresh exit timing");
   self_tick_a: assert property ($rose(o_self_refresh) |-> ##[1:300] o_act.ref_valid)
      else $error("no internal refresh");
   pre_bl8_a: assert property (acc && i_cmd.addr[10] && i_burst_len == 3'h3 ##1 (!(acc || bst))[*8]
      |-> ##3 o_act.pre_valid && o_act.pre_bank == $past(i_cmd.bank, 11))
      else $error("auto precharge late or wrong bank");
   ap_only_a: assert property (o_act.pre_valid |-> ap_ff)
      else $error("precharge without request");
   burst_stop_a: assert property (bst && o_burst_active |-> ##[1:3] !o_burst_active)
      else $error("burst not truncated");
endmodule // sdpr_chk
bind sdpr_ctrl sdpr_chk u_sdpr_chk (.i_core_clk(i_core_clk), .i_srst(i_srst), .i_cmd(i_cmd),
   .i_burst_len(i_burst_len), .o_act(o_act), .o_self_refresh(o_self_refresh), .o_burst_active(o_burst_active));

/* File: test/sdpr_host_model.sv */
// Purpose: Memory controller model driving the command pins
// Assumes: Pins change 1 ns after the rising edge
// Notes: Released address shows the inverse of its last value
`timescale 1ns/1ns
module sdpr_host_model #(
   // Refresh interval in cycles, 64 ms over 8192 rows
   parameter int REF_GAP = 390
) (
   // Clock
   input wire logic i_core_clk,
   // Command pins
   output sdpr_pkg::sdpr_cmd_s o_cmd
);
   import sdpr_pkg::*;
   initial o_cmd = {4'hf, 1'b1, 15'h0};
   int gap_ff;
   always @(posedge i_core_clk) begin
      if ({o_cmd.cs_n, o_cmd.ras_n, o_cmd.cas_n, o_cmd.we_n} == 4'h1 && o_cmd.cke)
         gap_ff <= 0;
      else
         gap_ff <= gap_ff + 1;
   end
   task automatic send(input logic [3:0] pins, input logic cke, input logic [14:0] ba);
      @(posedge i_core_clk);
      #1;
      o_cmd = {pins, cke, ba};
   endtask
   task automatic idle(input int n, input logic cke);
      @(posedge i_core_clk);
      #1;
      o_cmd = {4'h7, cke, ~o_cmd[14:0]};
      repeat (n) @(posedge i_core_clk);
      #1;
   endtask
   task automatic self_ref(input int hold);
      send(4'h1, 1'b0, 15'h0);
      idle(hold, 1'b0);
      send(4'h5, 1'b0, 15'h0400);
      idle(hold, 1'b0);
      idle(8, 1'b1);
      send(4'h1, 1'b1, 15'h0);
      idle(6, 1'b1);
   endtask
   // refresh first when due, access waits
   task automatic ref_if_due();
      if (gap_ff >= REF_GAP) begin
         send(4'h1, 1'b1, 15'h0);
         idle(4, 1'b1);
      end
   endtask
   // all rows back to back, four clocks apart
   task automatic ref_burst(input int n);
      for (int i = 0; i < n; i++) begin
         send(4'h1, 1'b1, 15'h0);
         idle(2, 1'b1);
      end
      idle(4, 1'b1);
   endtask
endmodule // sdpr_host_model

/* File: test/tb_sdpr_ctrl.sv */
// Purpose: Self-checking bench for sdpr_ctrl
// Assumes: Controller model drives all command pins
// Notes: Random columns and modes from a fixed seed
`timescale 1ns/1ns
`include "sdpr_map.svh"
module tb_sdpr_ctrl;
   import sdpr_pkg::*;
   logic i_core_clk, i_srst, o_self_refresh, o_burst_active;
   logic [2:0] i_burst_len;
   logic [1:0] last_bank;
   logic [12:0] last_row;
   logic [12:0] row0;
   logic [31:0] r;
   sdpr_cmd_s i_cmd;
   sdpr_act_s o_act;
   int n_errors, cmp_count, seed, n_pre, n_ref, k0;
   sdpr_ctrl u_sdpr_ctrl (.i_core_clk(i_core_clk), .i_srst(i_srst), .i_cmd(i_cmd), .i_burst_len(i_burst_len),
      .o_act(o_act), .o_self_refresh(o_self_refresh), .o_burst_active(o_burst_active));
   // Short interval so the refresh scheduler acts between accesses
   sdpr_host_model #(.REF_GAP(100)) u_sdpr_host_model (.i_core_clk(i_core_clk), .o_cmd(i_cmd));
   initial begin
      i_core_clk = 1'b0;
      forever #10 i_core_clk = ~i_core_clk;
   end
   always @(posedge i_core_clk) begin
      if (o_act.pre_valid === 1'b1) begin
         n_pre++;
         last_bank = o_act.pre_bank;
      end
      if (o_act.ref_valid === 1'b1) begin
         n_ref++;
         last_row = o_act.ref_row;
      end
   end
   task automatic check(input string what, input logic [18:0] seen, input logic [18:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_errors++;
         $display("BAD %s exp %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wrap_up;
      $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   function automatic int exp_pre(input logic a10, input logic [2:0] bl, input logic stop);
      return (a10 && bl != 3'h7 && !stop) ? 1 : 0;
   endfunction
   // Access, optionally led by a replaced access and cut by a terminate
   task automatic acc(input logic w, a10, input logic [2:0] bl, input logic [1:0] bk, input logic lead, stop);
      i_burst_len = bl;
      n_pre = 0;
      last_bank = ~bk;
      stop = stop && bl[1] && bl[0];
      u_sdpr_host_model.ref_if_due();
      if (lead)
         u_sdpr_host_model.send(4'h5, 1'b1, {~bk, 2'h0, ~a10, 10'h0});
      u_sdpr_host_model.send({3'h2, ~w}, 1'b1, {bk, 2'h0, a10, 10'($random(seed))});
      if (stop) begin
         u_sdpr_host_model.idle(3, 1'b1);
         u_sdpr_host_model.send(4'h6, 1'b1, 15'h0);
      end
      u_sdpr_host_model.idle(14, 1'b1);
      check("pre count", 19'(n_pre), 19'(exp_pre(a10, bl, stop)));
      check("pre bank", 19'(last_bank), 19'(exp_pre(a10, bl, stop) != 0 ? bk : 2'(~bk)));
      check("burst", 19'(o_burst_active), 19'(bl == 3'h7 && !stop));
   endtask
   initial begin
      seed = 32'h53c011d3;
      i_srst = 1'b1;
      i_burst_len = 3'h0;
      repeat (6) @(posedge i_core_clk);
      #1;
      i_srst = 1'b0;
      check("reset", {o_act, o_self_refresh, o_burst_active}, 19'h0);
      for (int k = 0; k < 3; k++) begin
         u_sdpr_host_model.send(4'h1, 1'b1, 15'($random(seed)));
         u_sdpr_host_model.idle(5, 1'b1);
         check("ref row", 19'(last_row), 19'(k));
      end
      $display("refresh test done");
      acc(1'b0, 1'b1, 3'h3, 2'h2, 1'b0, 1'b0);
      acc(1'b1, 1'b1, 3'h7, 2'h1, 1'b0, 1'b1);
      acc(1'b0, 1'b1, 3'h0, 2'h3, 1'b1, 1'b0);
      for (int k = 0; k < 16; k++) begin
         r = $random(seed);
         acc(r[0], r[1], r[4] ? 3'h7 : r[4:2], r[6:5], r[7], r[8]);
      end
      acc(1'b0, 1'b0, 3'h0, 2'h0, 1'b0, 1'b0);
      $display("access test done");
      k0 = n_ref;
      n_pre = 0;
      u_sdpr_host_model.self_ref(200);
      check("self refs", 19'(n_ref - k0 > 1), 19'h1);
      check("self exit", 19'(o_self_refresh), 19'h0);
      check("self pre", 19'(n_pre), 19'h0);
      $display("self refresh test done");
      row0 = last_row;
      k0 = n_ref;
      u_sdpr_host_model.ref_burst(`SDPR_ROWS);
      check("burst refs", 19'(n_ref - k0), 19'(`SDPR_ROWS));
      check("wrapped row", 19'(last_row), 19'(row0));
      $display("refresh burst test done");
      i_srst = 1'b1;
      repeat (3) @(posedge i_core_clk);
      #1;
      i_srst = 1'b0;
      u_sdpr_host_model.send(4'h1, 1'b1, 15'h1fff);
      u_sdpr_host_model.idle(5, 1'b1);
      check("row after reset", 19'(last_row), 19'h0);
      $display("reset test done");
      wrap_up();
   end
   initial begin
      // About 50000 cycles, well past the refresh burst
      #1000000;
      n_errors++;
      wrap_up();
   end
endmodule // tb_sdpr_ctrl
